// File: scl_config_latches.sv
// Module: serdes channel configuration latch banks and decoded controls
`timescale 1ns/10ps
module scl_config_latches (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic [6:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [6:0] RDATA,
  input wire logic [1:0] SPEED_RANGE_SEL,
  input wire logic [1:0] TX_INPUT_CLOCK,
  output scl_pkg::scl_tx_t [1:0] TX_CTRL,
  output scl_pkg::scl_rx_t [1:0] RX_CTRL
);

  // ==========================================================
  // Latch banks
  logic [6:0] bank_q [scl_pkg::NBANK];
  logic [6:0] rdata_q;
  logic [1:0] spd_s1_q;
  logic [1:0] spd_s2_q;
  logic [1:0] txc_s1_q;
  logic [1:0] txc_s2_q;
  logic [1:0] txc_s3_q;
  logic [1:0] txc_rise;
  logic [1:0] pab_req;
  logic [1:0] pab_done;
  logic [1:0] tx_rate;
  logic [1:0] tx_cksel;
  logic [1:0] tx_bist_off;
  logic [1:0] tx_oe1;
  logic [1:0] tx_oe2;
  logic [1:0] rx_rate;
  logic [1:0] rx_sda1 [scl_pkg::NRX];
  logic [1:0] rx_sda2 [scl_pkg::NRX];
  scl_pkg::scl_tx_t tx_q [scl_pkg::NTX];
  scl_pkg::scl_rx_t rx_q [scl_pkg::NRX];

  // Every bank is a plain word; the buffer reset bit of a tx
  // dynamic bank also returns to 1 once its request is taken
  for (genvar i = 0; i < scl_pkg::NBANK; i++) begin : g_bank
    localparam int KIND = i % scl_pkg::BANKS_PER_CH;
    localparam logic [6:0] RV =
      (KIND == scl_pkg::BK_STAT0) ? scl_pkg::RST_STAT0 :
      (KIND == scl_pkg::BK_STAT1) ? scl_pkg::RST_STAT1 :
      scl_pkg::RST_DYN;
    localparam bit PAB_BANK = (KIND == scl_pkg::BK_DYN) &&
      (i < scl_pkg::RX_BASE);
    localparam int CH = (i / scl_pkg::BANKS_PER_CH) % 2;
    // A new write wins over the self-clear in the same cycle
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        bank_q[i] <= RV; // [RQ1] [RQ5] [RQ6] [RQ7] [RQ10] [RQ13] [RQ15] [RQ16]
      end else if (WR && ADDR == bank_addr(i)) begin
        bank_q[i] <= WDATA; // [RQ17] [RQ19]
      end else if (PAB_BANK && pab_done[CH]) begin
        bank_q[i][scl_pkg::PAB_BIT] <= 1'b1; // [RQ12]
      end
    end
  end

  // Address of a bank index at port width
  function automatic logic [3:0] bank_addr(input int idx);
    bank_addr = idx[3:0];
  endfunction

  // ==========================================================
  // Pin synchronisers
  // Speed select is a strap pin, so it is only used after two flops
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      spd_s1_q <= 2'h0;
      spd_s2_q <= 2'h0;
    end else begin
      spd_s1_q <= SPEED_RANGE_SEL;
      spd_s2_q <= spd_s1_q;
    end
  end

  // Tx input clock is sampled as data; its rise is seen two
  // flops late, which only delays the buffer re-centre pulse and self-clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      txc_s1_q <= 2'h0;
      txc_s2_q <= 2'h0;
      txc_s3_q <= 2'h0;
    end else begin
      txc_s1_q <= TX_INPUT_CLOCK;
      txc_s2_q <= txc_s1_q;
      txc_s3_q <= txc_s2_q;
    end
  end

  assign txc_rise = txc_s2_q & ~txc_s3_q;

  // ==========================================================
  // Transmit channels
  for (genvar c = 0; c < scl_pkg::NTX; c++) begin : g_tx
    localparam int B0 = c * scl_pkg::BANKS_PER_CH;
    assign tx_rate[c] = bank_q[B0 + scl_pkg::BK_STAT1][scl_pkg::TXRATE_BIT];
    assign tx_cksel[c] = bank_q[B0 + scl_pkg::BK_STAT1][scl_pkg::TXCKSEL_BIT];
    assign tx_bist_off[c] = bank_q[B0 + scl_pkg::BK_DYN][scl_pkg::TXBIST_BIT];
    assign tx_oe1[c] = bank_q[B0 + scl_pkg::BK_DYN][scl_pkg::OE1_BIT];
    assign tx_oe2[c] = bank_q[B0 + scl_pkg::BK_DYN][scl_pkg::OE2_BIT];
    // Written 0 means a re-centre is pending
    assign pab_req[c] = ~bank_q[B0 + scl_pkg::BK_DYN][scl_pkg::PAB_BIT]; // [RQ10]
    assign pab_done[c] = pab_req[c] & txc_rise[c]; // [RQ11]

    // Decoded transmit controls, all registered
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        tx_q[c] <= '0; // [RQ9]
        tx_q[c].chan_power_down <= 1'b1;
      end else begin
        tx_q[c].pll_mult20 <= tx_rate[c]; // [RQ1] [RQ2]
        tx_q[c].clk_out_double <= tx_rate[c]; // [RQ2]
        tx_q[c].ddr_capture <= tx_rate[c] & tx_cksel[c]; // [RQ3]
        tx_q[c].selftest_en <= ~tx_bist_off[c]; // [RQ5]
        tx_q[c].primary_drv_en <= tx_oe1[c]; // [RQ7]
        tx_q[c].secondary_drv_en <= tx_oe2[c]; // [RQ6]
        tx_q[c].chan_power_down <= ~tx_oe1[c] & ~tx_oe2[c]; // [RQ8]
        tx_q[c].pab_reset_pulse <= pab_done[c]; // [RQ10]
        // Flags the reserved combination the host must avoid
        tx_q[c].rate_invalid <= tx_rate[c] & ~spd_s2_q[c]; // [RQ4]
      end
    end

    assign TX_CTRL[c] = tx_q[c];
  end

  // ==========================================================
  // Receive channels
  for (genvar c = 0; c < scl_pkg::NRX; c++) begin : g_rx
    localparam int B0 = scl_pkg::RX_BASE + c * scl_pkg::BANKS_PER_CH;
    assign rx_rate[c] = bank_q[B0 + scl_pkg::BK_STAT0][scl_pkg::RXRATE_BIT];
    assign rx_sda1[c] = bank_q[B0 + scl_pkg::BK_STAT1][scl_pkg::SDA1_LSB +: 2];
    assign rx_sda2[c] = bank_q[B0 + scl_pkg::BK_STAT1][scl_pkg::SDA2_LSB +: 2];

    // Code 00 turns the analog detector off
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        rx_q[c] <= '0;
      end else begin
        rx_q[c].clk_half_rate <= rx_rate[c]; // [RQ13] [RQ14]
        rx_q[c].pri_threshold <= rx_sda1[c]; // [RQ15]
        rx_q[c].sec_threshold <= rx_sda2[c]; // [RQ16]
        rx_q[c].pri_det_en <= rx_sda1[c] != scl_pkg::SDA_OFF; // [RQ15]
        rx_q[c].sec_det_en <= rx_sda2[c] != scl_pkg::SDA_OFF; // [RQ16]
      end
    end

    assign RX_CTRL[c] = rx_q[c];
  end

  // ==========================================================
  // Read port
  // Readback is a debug aid; data stands for one cycle only
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 7'h00;
    end else if (RD && ADDR < bank_addr(scl_pkg::NBANK)) begin
      rdata_q <= bank_q[ADDR];
    end else if (RD && ADDR == scl_pkg::ADDR_STATUS) begin
      rdata_q <= {3'h0, pab_req, tx_q[1].rate_invalid, tx_q[0].rate_invalid};
    end else begin
      rdata_q <= 7'h00;
    end
  end

  assign RDATA = rdata_q;

  // ==========================================================
  // Checks
  logic live_q;

  // Set from the second edge out of reset; the decoded flops still
  // show their reset zeros at the first edge, not the bank decode
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  property p_tx_rate;
    live_q |=> TX_CTRL[0].pll_mult20 == $past(tx_rate[0]);
  endproperty
  a_tx_rate: assert property (p_tx_rate) else $error("tx rate mismatch"); // [RQ2]

  property p_ddr;
    tx_rate[1] && tx_cksel[1] |=> TX_CTRL[1].ddr_capture;
  endproperty
  a_ddr: assert property (p_ddr) else $error("ddr capture missing"); // [RQ3]

  property p_bist;
    !tx_bist_off[0] |=> TX_CTRL[0].selftest_en;
  endproperty
  a_bist: assert property (p_bist) else $error("self-test not enabled"); // [RQ5]

  property p_sec;
    WR && ADDR == 4'h2 ##1 1 |=> TX_CTRL[0].secondary_drv_en == $past(WDATA[2], 2);
  endproperty
  a_sec: assert property (p_sec) else $error("secondary driver wrong"); // [RQ6]

  property p_pri;
    WR && ADDR == 4'h5 ##1 1 |=> TX_CTRL[1].primary_drv_en == $past(WDATA[1], 2);
  endproperty
  a_pri: assert property (p_pri) else $error("primary driver wrong"); // [RQ7]

  property p_pwrdn;
    TX_CTRL[0].chan_power_down |->
      !TX_CTRL[0].primary_drv_en && !TX_CTRL[0].secondary_drv_en;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("power down with driver on"); // [RQ8]

  property p_pab_clear;
    pab_done[0] && !(WR && ADDR == 4'h2) |=> !pab_req[0] ##0 TX_CTRL[0].pab_reset_pulse;
  endproperty
  a_pab_clear: assert property (p_pab_clear) else $error("buffer reset not cleared"); // [RQ12]

  property p_pab_wait;
    pab_req[1] && !txc_rise[1] && !(WR && ADDR == 4'h5) |=> pab_req[1] ##0 !TX_CTRL[1].pab_reset_pulse;
  endproperty
  a_pab_wait: assert property (p_pab_wait) else $error("buffer reset early"); // [RQ11]

  property p_write;
    WR && ADDR == 4'h7 |=> bank_q[7] == $past(WDATA);
  endproperty
  a_write: assert property (p_write) else $error("bank write lost"); // [RQ17]

  property p_hold;
    !(WR && ADDR == 4'h6) |=> $stable(bank_q[6]);
  endproperty
  a_hold: assert property (p_hold) else $error("bank changed unwritten"); // [RQ19]

  property p_rxrate;
    live_q |=> RX_CTRL[0].clk_half_rate == $past(rx_rate[0]);
  endproperty
  a_rxrate: assert property (p_rxrate) else $error("rx rate mismatch"); // [RQ13]

  property p_sda;
    rx_sda1[1] == 2'h0 |=> !RX_CTRL[1].pri_det_en;
  endproperty
  a_sda: assert property (p_sda) else $error("detector not off"); // [RQ15]

  property p_rdata;
    !RD |=> RDATA == 7'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");

  property p_tx_double;
    live_q |=> TX_CTRL[1].clk_out_double == $past(tx_rate[1]);
  endproperty
  a_tx_double: assert property (p_tx_double) else $error("tx clock rate wrong"); // [RQ2]

  property p_mult10;
    live_q && !tx_rate[0] |=> !TX_CTRL[0].pll_mult20;
  endproperty
  a_mult10: assert property (p_mult10) else $error("pll not times ten"); // [RQ1]

  property p_ddr_off;
    !tx_cksel[0] |=> !TX_CTRL[0].ddr_capture;
  endproperty
  a_ddr_off: assert property (p_ddr_off) else $error("ddr capture without clock select"); // [RQ3]

  property p_pab_once;
    TX_CTRL[0].pab_reset_pulse |=> !TX_CTRL[0].pab_reset_pulse;
  endproperty
  a_pab_once: assert property (p_pab_once) else $error("buffer reset pulse too long"); // [RQ12]

  property p_pri_thr;
    live_q |=> RX_CTRL[1].pri_threshold == $past(rx_sda1[1]);
  endproperty
  a_pri_thr: assert property (p_pri_thr) else $error("primary threshold wrong"); // [RQ15]

  property p_sec_thr;
    live_q |=> RX_CTRL[0].sec_threshold == $past(rx_sda2[0]);
  endproperty
  a_sec_thr: assert property (p_sec_thr) else $error("secondary threshold wrong"); // [RQ16]

  property p_sec_off;
    rx_sda2[0] == 2'h0 |=> !RX_CTRL[0].sec_det_en;
  endproperty
  a_sec_off: assert property (p_sec_off) else $error("secondary detector not off"); // [RQ16]

  property p_rd_bank;
    RD && ADDR == 4'h7 |=> RDATA == $past(bank_q[7]);
  endproperty
  a_rd_bank: assert property (p_rd_bank) else $error("bank readback wrong"); // [RQ17]

  property p_status;
    RD && ADDR == scl_pkg::ADDR_STATUS |=> RDATA[3:2] == $past(pab_req);
  endproperty
  a_status: assert property (p_status) else $error("pending buffer reset not shown"); // [RQ10]

  c_pab: cover property (pab_done[0]);
  c_pab_b: cover property (pab_done[1]);
  c_ddr: cover property (TX_CTRL[1].ddr_capture);
  c_rate_bad: cover property (TX_CTRL[0].rate_invalid);
  c_both_drv: cover property (TX_CTRL[0].primary_drv_en && TX_CTRL[0].secondary_drv_en);

endmodule

// File: scl_pkg.sv
// Package: constants and carriers for the serdes channel configuration latches
// Functional notes
// RQ1: Tx rate latch resets 0: PLL times 10
// RQ2: Tx rate latch 1: PLL times 20
// RQ3: Clock select 1, rate 1: capture both edges
// RQ4: Host never sets rate 1 with slow speed
// RQ5: Tx self-test disable resets 1; 0 enables it
// RQ6: Secondary driver enable resets 0; 1 drives data
// RQ7: Primary driver enable resets 0; 1 drives data
// RQ8: Disabled drivers power down; both off, channel down
// RQ9: Device reset disables every serial driver
// RQ10: Buffer reset resets 1; writing 0 re-centres buffer
// RQ11: Buffer reset sampled on tx input clock rise
// RQ12: Buffer reset latch clears itself after use
// RQ13: Rx rate resets 1: half-rate complementary clocks
// RQ14: Rx rate 0: full-rate complementary clocks
// RQ15: Primary detector select resets 10; 00 disables
// RQ16: Secondary detector select resets 10, same decode
// RQ17: Twelve seven-bit banks written while strobe active
// RQ18: Host drives fixed bit positions with fixed values
// RQ19: Fields hold until rewrite or reset
package scl_pkg;
  // ==========================================================
  // Geometry and offsets
  localparam int NBANK = 12;
  localparam int AW = 4;
  localparam int DW = 7;
  localparam int NTX = 2;
  localparam int NRX = 2;
  localparam int BANKS_PER_CH = 3;
  localparam int RX_BASE = 6;
  localparam int BK_STAT0 = 0;
  localparam int BK_STAT1 = 1;
  localparam int BK_DYN = 2;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  // ==========================================================
  // Reset values per bank kind
  localparam logic [6:0] RST_STAT0 = 7'h5F;
  localparam logic [6:0] RST_STAT1 = 7'h56;
  localparam logic [6:0] RST_DYN = 7'h59;
  // ==========================================================
  // Field positions
  localparam int TXRATE_BIT = 0;
  localparam int TXCKSEL_BIT = 1;
  localparam int PAB_BIT = 0;
  localparam int OE1_BIT = 1;
  localparam int OE2_BIT = 2;
  localparam int TXBIST_BIT = 3;
  localparam int RXRATE_BIT = 0;
  localparam int SDA1_LSB = 3;
  localparam int SDA2_LSB = 5;
  localparam logic [1:0] SDA_OFF = 2'h0;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic pll_mult20;
    logic clk_out_double;
    logic ddr_capture;
    logic selftest_en;
    logic primary_drv_en;
    logic secondary_drv_en;
    logic chan_power_down;
    logic pab_reset_pulse;
    logic rate_invalid;
  } scl_tx_t;
  typedef struct packed {
    logic clk_half_rate;
    logic [1:0] pri_threshold;
    logic [1:0] sec_threshold;
    logic pri_det_en;
    logic sec_det_en;
  } scl_rx_t;
endpackage

// File: scl_host.sv
// Host model that drives the configuration port of the latch banks
`timescale 1ns/10ps
module scl_host (
  input wire logic clk,
  input wire logic [6:0] rdata,
  output logic [3:0] addr,
  output logic [6:0] wdata,
  output logic wr,
  output logic rd
);
  // ==========================================================
  // Idle bus
  initial begin
    addr = 4'h0;
    wdata = 7'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ==========================================================
  // One-cycle write; caller supplies the fixed bank bits
  task automatic wr_bank(input logic [3:0] a, input logic [6:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d; // Released data never shows the stale word
  endtask
  // One-cycle read; data is taken only in the following cycle
  task automatic rd_bank(input logic [3:0] a, output logic [6:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// File: serdes_channel_config_latches_tb_top.sv
// Testbench for the serdes channel configuration latch banks
`timescale 1ns/10ps
module serdes_channel_config_latches_tb_top;
  typedef struct packed {
    logic [3:0] a;
    logic [6:0] d;
    logic rx;
    logic ch;
    logic [8:0] e;
  } scl_row_t;
  // ==========================================================
  // Ordinary cases: write, then expected decode of that channel
  localparam scl_row_t rows [14] = '{
    '{4'h1, 7'h53, 1'b0, 1'b0, 9'h1C4},
    '{4'h2, 7'h5B, 1'b0, 1'b0, 9'h1D0},
    '{4'h2, 7'h5D, 1'b0, 1'b0, 9'h1C8},
    '{4'h2, 7'h57, 1'b0, 1'b0, 9'h1F8},
    '{4'h1, 7'h50, 1'b0, 1'b0, 9'h038},
    '{4'h1, 7'h52, 1'b0, 1'b0, 9'h038},
    '{4'h4, 7'h53, 1'b0, 1'b1, 9'h1C4},
    '{4'h6, 7'h40, 1'b1, 1'b0, 9'h02B},
    '{4'h7, 7'h00, 1'b1, 1'b0, 9'h000},
    '{4'h7, 7'h08, 1'b1, 1'b0, 9'h012},
    '{4'h7, 7'h78, 1'b1, 1'b0, 9'h03F},
    '{4'hA, 7'h20, 1'b1, 1'b1, 9'h045},
    '{4'h6, 7'h41, 1'b1, 1'b0, 9'h07F},
    '{4'h7, 7'h50, 1'b1, 1'b0, 9'h06B}
  };
  logic clk;
  logic nrst;
  logic [3:0] addr;
  logic [6:0] wdata;
  logic [6:0] rdata;
  logic wr;
  logic rd;
  logic [1:0] speed;
  logic [1:0] txclk;
  logic [6:0] got;
  scl_pkg::scl_tx_t [1:0] tx;
  scl_pkg::scl_rx_t [1:0] rx;
  int errors;
  int check_count;
  int n;
  scl_config_latches uut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SPEED_RANGE_SEL(speed), .TX_INPUT_CLOCK(txclk), .TX_CTRL(tx), .RX_CTRL(rx));
  scl_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  // ==========================================================
  // Clock and checking helpers
  always #5 clk = ~clk;
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    speed = 2'h3; // Fast range, so rate 1 is legal
    txclk = 2'h0;
    errors = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    // Decode of the bank reset values on both channels
    for (int c = 0; c < 2; c++) begin
      cmp({tx[c]}, 9'h004);
      cmp({2'h0, rx[c]}, 9'h06B);
    end
    for (int i = 0; i < 12; i++) begin
      host.rd_bank(4'(i), got);
      cmp({2'h0, got}, (i % 3 == 0) ? 9'h05F : (i % 3 == 1) ? 9'h056 : 9'h059);
    end
    // Table of ordinary writes, each read back at once
    foreach (rows[i]) begin
      host.wr_bank(rows[i].a, rows[i].d);
      @(posedge clk);
      #1;
      cmp(rows[i].rx ? {2'h0, rx[rows[i].ch]} : {tx[rows[i].ch]}, rows[i].e);
      host.rd_bank(rows[i].a, got);
      cmp({2'h0, got}, {2'h0, rows[i].d});
    end
    // Write to the status slot must leave the latches alone
    host.wr_bank(4'hC, 7'h00);
    @(posedge clk);
    #1;
    cmp({tx[0]}, 9'h038);
    // Buffer reset on both channels waits for a rising input clock, then clears itself
    host.wr_bank(4'h2, 7'h56);
    host.wr_bank(4'h5, 7'h58);
    repeat (3) @(posedge clk);
    #1;
    cmp({7'h00, tx[1].pab_reset_pulse, tx[0].pab_reset_pulse}, 9'h000);
    host.rd_bank(4'hC, got);
    cmp({2'h0, got}, 9'h00C);
    @(posedge clk);
    txclk <= 2'h3;
    n = 0;
    while (tx[0].pab_reset_pulse !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 10) begin
      errors++;
      end_of_test();
    end
    cmp({7'h00, tx[1].pab_reset_pulse, tx[0].pab_reset_pulse}, 9'h003);
    @(posedge clk);
    #1;
    cmp({7'h00, tx[1].pab_reset_pulse, tx[0].pab_reset_pulse}, 9'h000);
    host.rd_bank(4'h2, got);
    cmp({2'h0, got}, 9'h057);
    host.rd_bank(4'h5, got);
    cmp({2'h0, got}, 9'h059);
    // Mid-run reset drops every driver at once, no clock needed
    @(posedge clk);
    #2;
    nrst = 1'b0;
    #1;
    cmp({5'h00, tx[0].primary_drv_en, tx[0].secondary_drv_en, tx[1].primary_drv_en, tx[1].secondary_drv_en},
      9'h000);
    end_of_test();
  end
endmodule
